// ### hw/swh_hub_end.sv
// hub end of the wake handshake: startup strap, irq or wake line, deep sleep
// the byte-level two-wire slave lives with the user side; this end sees
// the decoded busy level and received commands on its user ports
// pins arrive already synchronous to sys_clk, so no extra flops on them
// open-drain pins: the output level stays low and the enable pulls
// the line; the board supplies the pull-ups
// Contract
// - strap line at reset release picks mode
// - standard firmware drives line as host interrupt
// - low-power firmware takes line as wake input
// - host masters bus, clock input, data bidirectional
// - low-power firmware never interrupts the host
// - sleep when idle; wake on timer, sensor, line
// - host lowers line 250 us before start
// - host holds line low whole exchange
// - host raises line after; hub may sleep
// - host polls periodically for reports
// - default one report per sample, 40 ms
// - host polls every five report periods
// - bootloader entry: reset and strap timing
// - bootloader falls to application after 780 ms
// - application accepts commands about one second
`timescale 1ns/1ps
module swh_hub_end
  import swh_pkg::*;
#(
  parameter int BOOT_WAIT = BOOT_WAIT_CYC,
  parameter int BOOT_READY = BOOT_READY_CYC,
  parameter int APP_READY = APP_READY_CYC,
  parameter int REPORT_PERIOD = REPORT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // link
  swh_link_if.hub link,
  // firmware build and wake sources
  input wire logic lowPowerBuild,
  input wire logic appValid,
  input wire logic rtcEvent,
  input wire logic sensorEvent,
  // two-wire slave state and commands
  input wire logic busBusy,
  input wire logic sdaDrive,
  input wire logic cmdValid,
  input wire logic [23:0] cmdBytes,
  // report consumption
  input wire logic reportTaken,
  // status
  output logic bootMode,
  output logic cmdReady,
  output logic asleep,
  output logic reportPulse,
  output logic [7:0] reportRate
);
  swh_hub_state_type state_ff;
  swh_hub_state_type nxt_state;
  logic [31:0] timer_ff;
  logic [31:0] repCnt_ff;
  logic [7:0] rate_ff;
  logic [7:0] sampleCnt_ff;
  logic irqPend_ff;
  logic bootMode_ff;
  logic repPulse_ff;
  logic sdaPrev_ff;
  logic busOpen_ff;

  wire lineLow = ~link.hostWakeIrqLine;
  wire timerDone = (timer_ff == 32'h0);
  wire bootCmd = cmdValid && (cmdBytes == BOOT_ENTER_CMD);
  wire rateCmd = cmdValid && (cmdBytes[23:8] == OUT_MODE_CMD);
  // line low, timer or sensor all wake
  wire wakeSrc = rtcEvent | sensorEvent | lineLow;
  // never sleep under a held line or an open exchange
  wire mayIdle = ~lineLow & ~busBusy & ~busOpen_ff & ~irqPend_ff;
  // start: data falls while clock high; idle: both lines high
  wire startCond = link.sclLine && sdaPrev_ff && ~link.sdaLine;
  wire busIdle = link.sclLine && link.sdaLine;
  // samples keep running in sleep, as the timer wake implies
  wire sampleTick = (repCnt_ff == 32'h0);
  wire reportDue = sampleTick && (sampleCnt_ff + 8'h01 >= rate_ff);

  // state walk
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HUB_RESET: begin
        nxt_state = lineLow ? HUB_BOOT_WAIT : HUB_APP_INIT;
      end
      HUB_BOOT_WAIT: begin
        if (timerDone) nxt_state = HUB_BOOT;
      end
      HUB_BOOT: begin
        if (timerDone && appValid && ~bootMode_ff) nxt_state = HUB_APP_INIT;
      end
      HUB_APP_INIT: begin
        if (timerDone) nxt_state = HUB_ACTIVE;
      end
      HUB_ACTIVE: begin
        if (lowPowerBuild && mayIdle && ~wakeSrc) nxt_state = HUB_SLEEP;
      end
      HUB_SLEEP: begin
        if (wakeSrc) nxt_state = HUB_ACTIVE;
      end
      default: nxt_state = HUB_RESET;
    endcase
  end

  // one down-counter serves every startup phase, as only one runs at a time
  // mode, timers and state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= HUB_RESET;
      timer_ff <= 32'h0;
      bootMode_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      if (state_ff == HUB_RESET && nxt_state == HUB_BOOT_WAIT) begin
        timer_ff <= 32'(BOOT_READY);
      end else if (state_ff == HUB_BOOT_WAIT && timerDone) begin
        timer_ff <= 32'(BOOT_WAIT);
      end else if (nxt_state == HUB_APP_INIT && state_ff != HUB_APP_INIT) begin
        timer_ff <= 32'(APP_READY);
      end else if (!timerDone) begin
        timer_ff <= timer_ff - 32'h1;
      end
      // entry command latches bootloader for good
      if (state_ff == HUB_BOOT && bootCmd) bootMode_ff <= 1'b1;
    end
  end

  // report rate, default one per sample
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_ff <= RATE_RESET;
    end else if (clkEn && rateCmd && state_ff == HUB_ACTIVE) begin
      rate_ff <= (cmdBytes[7:0] == 8'h00) ? RATE_RESET : cmdBytes[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      repCnt_ff <= 32'h0;
      sampleCnt_ff <= 8'h0;
      repPulse_ff <= 1'b0;
    end else if (clkEn) begin
      repPulse_ff <= 1'b0;
      if (state_ff == HUB_ACTIVE || state_ff == HUB_SLEEP) begin
        repCnt_ff <= sampleTick ? 32'(REPORT_PERIOD - 1) : repCnt_ff - 32'h1;
        if (sampleTick) begin
          sampleCnt_ff <= reportDue ? 8'h0 : sampleCnt_ff + 8'h01;
          repPulse_ff <= reportDue;
        end
      end
    end
  end

  // two-wire exchange seen on the pins
  // reset to the idle high level so release gives no false start
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaPrev_ff <= 1'b1;
      busOpen_ff <= 1'b0;
    end else if (clkEn) begin
      sdaPrev_ff <= link.sdaLine;
      // a start wins; a stop leaves both lines high, which ends it
      if (startCond) busOpen_ff <= 1'b1;
      else if (busIdle) busOpen_ff <= 1'b0;
    end
  end

  // pending report flag; a new report wins over a take
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqPend_ff <= 1'b0;
    end else if (clkEn) begin
      if (repPulse_ff) irqPend_ff <= 1'b1;
      else if (reportTaken) irqPend_ff <= 1'b0;
    end
  end

  // low-power build only listens
  // pulling low is the only drive; the pull-up returns the line high
  wire irqMode = (state_ff == HUB_ACTIVE) && ~lowPowerBuild && ~bootMode_ff;
  assign link.wakeHubOut = 1'b0;
  assign link.wakeHubOe = irqMode && irqPend_ff;
  // hub only ever pulls data low
  assign link.sdaHubOut = 1'b0;
  assign link.sdaHubOe = sdaDrive;

  // status outputs
  assign bootMode = bootMode_ff;
  assign cmdReady = (state_ff == HUB_ACTIVE) || (state_ff == HUB_BOOT);
  assign asleep = (state_ff == HUB_SLEEP);
  assign reportPulse = repPulse_ff;
  assign reportRate = rate_ff;
endmodule : swh_hub_end

// ### hw/swh_pkg.sv
// constants shared by the hub end and the host end of the wake handshake
// assumes a single 50 MHz clock shared by both ends
package swh_pkg;
  localparam int CLK_HZ = 50000000;
  // wake lead time before a start condition, microseconds
  localparam int WAKE_LEAD_US = 250;
  localparam int WAKE_LEAD_CYC = (WAKE_LEAD_US * (CLK_HZ / 1000000));
  // reset and strap timings, milliseconds
  localparam int RST_HOLD_MS = 10;
  localparam int STRAP_SETUP_MS = 1;
  localparam int BOOT_READY_MS = 50;
  localparam int BOOT_WAIT_MS = 780;
  localparam int APP_READY_MS = 1000;
  localparam int REPORT_MS = 40;
  localparam int POLL_REPORTS = 5;
  localparam int POLL_MS = REPORT_MS * POLL_REPORTS;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CYC_PER_MS;
  localparam int STRAP_SETUP_CYC = STRAP_SETUP_MS * CYC_PER_MS;
  localparam int BOOT_READY_CYC = BOOT_READY_MS * CYC_PER_MS;
  localparam int BOOT_WAIT_CYC = BOOT_WAIT_MS * CYC_PER_MS;
  localparam int APP_READY_CYC = APP_READY_MS * CYC_PER_MS;
  localparam int REPORT_CYC = REPORT_MS * CYC_PER_MS;
  localparam int POLL_CYC = POLL_MS * CYC_PER_MS;
  // bootloader-entry command and report-rate command prefix
  localparam logic [23:0] BOOT_ENTER_CMD = 24'h010008;
  localparam logic [15:0] OUT_MODE_CMD = 16'h1002;
  localparam logic [7:0] RATE_RESET = 8'h01;

  typedef enum logic [2:0] {
    HUB_RESET = 3'b000,
    HUB_BOOT_WAIT = 3'b001,
    HUB_BOOT = 3'b010,
    HUB_APP_INIT = 3'b011,
    HUB_ACTIVE = 3'b100,
    HUB_SLEEP = 3'b101
  } swh_hub_state_type;

  typedef enum logic [2:0] {
    HST_RESET = 3'b000,
    HST_RELEASE = 3'b001,
    HST_IDLE = 3'b010,
    HST_WAKE = 3'b011,
    HST_XFER = 3'b100
  } swh_host_state_type;
endpackage : swh_pkg

// ### hw/swh_link_if.sv
// pins between host and hub: reset, wake/irq line, two-wire bus
// open-drain lines resolve here as wired-and with pull-ups
`timescale 1ns/1ps
interface swh_link_if;
  logic hubResetLowInput;
  logic wakeHostOut;
  logic wakeHostOe;
  logic wakeHubOut;
  logic wakeHubOe;
  logic hostWakeIrqLine;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaHubOut;
  logic sdaHubOe;
  logic sclLine;
  logic sdaLine;
  // pulled-up wired-and of both drivers; the host alone drives the clock
  assign hostWakeIrqLine = (wakeHostOe ? wakeHostOut : 1'b1) & (wakeHubOe ? wakeHubOut : 1'b1);
  assign sclLine = sclHostOe ? sclHostOut : 1'b1;
  assign sdaLine = (sdaHostOe ? sdaHostOut : 1'b1) & (sdaHubOe ? sdaHubOut : 1'b1);
  modport hub (
    input hubResetLowInput, hostWakeIrqLine, sclLine, sdaLine,
    output wakeHubOut, wakeHubOe, sdaHubOut, sdaHubOe
  );
  modport host (
    input hostWakeIrqLine, sdaLine,
    output hubResetLowInput, wakeHostOut, wakeHostOe, sclHostOut, sclHostOe,
    output sdaHostOut, sdaHostOe
  );
endinterface : swh_link_if

// ### hw/swh_host_end.sv
// host end: drives hub reset and strap, wakes hub, polls on a timer
// the two-wire master engine lives on the user side; this end flags xferGo, its pin drives pass straight through
`timescale 1ns/1ps
module swh_host_end
  import swh_pkg::*;
#(
  parameter int RST_HOLD = RST_HOLD_CYC,
  parameter int WAKE_LEAD = WAKE_LEAD_CYC,
  parameter int POLL_PERIOD = POLL_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // link
  swh_link_if.host link,
  // user control
  input wire logic wantBoot,
  input wire logic restartReq,
  input wire logic lowPowerHub,
  input wire logic xferReq,
  input wire logic xferDone,
  // two-wire engine pins from user side
  input wire logic sclDrive,
  input wire logic sdaDrive,
  // user status
  output logic xferGo,
  output logic pollDue,
  output logic hubIrq
);
  swh_host_state_type state_ff;
  swh_host_state_type nxt_state;
  logic [31:0] timer_ff;
  logic [31:0] poll_ff;
  logic pollPend_ff;

  wire timerDone = (timer_ff == 32'h0);
  wire startXfer = xferReq | pollPend_ff;

  // state walk
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // reset held with strap set up
      HST_RESET: if (timerDone) nxt_state = HST_RELEASE;
      HST_RELEASE: nxt_state = HST_IDLE;
      HST_IDLE: begin
        if (restartReq) nxt_state = HST_RESET;
        else if (startXfer) nxt_state = lowPowerHub ? HST_WAKE : HST_XFER;
      end
      HST_WAKE: if (timerDone) nxt_state = HST_XFER;
      HST_XFER: if (xferDone) nxt_state = HST_IDLE;
      default: nxt_state = HST_RESET;
    endcase
  end

  // state and timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= HST_RESET;
      timer_ff <= 32'(RST_HOLD);
    end else if (clkEn) begin
      state_ff <= nxt_state;
      if (nxt_state == HST_RESET && state_ff != HST_RESET) timer_ff <= 32'(RST_HOLD);
      else if (nxt_state == HST_WAKE && state_ff != HST_WAKE) timer_ff <= 32'(WAKE_LEAD);
      else if (!timerDone) timer_ff <= timer_ff - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_ff <= 32'(POLL_PERIOD - 1);
      pollPend_ff <= 1'b0;
    end else if (clkEn) begin
      poll_ff <= (poll_ff == 32'h0) ? 32'(POLL_PERIOD - 1) : poll_ff - 32'h1;
      if (poll_ff == 32'h0 && lowPowerHub) pollPend_ff <= 1'b1;
      else if (state_ff == HST_XFER && xferDone) pollPend_ff <= 1'b0;
    end
  end

  // strap during reset; wake low in wake and transfer
  // strap still set at the edge where the hub samples it
  wire strapLow = (state_ff == HST_RESET || state_ff == HST_RELEASE) && wantBoot;
  wire wakeLow = lowPowerHub && (state_ff == HST_WAKE || state_ff == HST_XFER);
  assign link.hubResetLowInput = (state_ff != HST_RESET);
  assign link.wakeHostOut = 1'b0;
  assign link.wakeHostOe = strapLow | wakeLow;
  assign link.sclHostOut = 1'b0;
  assign link.sclHostOe = sclDrive;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe = sdaDrive;
  assign xferGo = (state_ff == HST_XFER);
  assign pollDue = pollPend_ff;
  assign hubIrq = ~link.hostWakeIrqLine && (state_ff == HST_IDLE) && ~lowPowerHub;
endmodule : swh_host_end

// ### verification/swh_link_asserts.sv
// link pin checker: wake line, hub reset, strap and bus gating
// assumes one clock; the bench hands in the hub build level
`timescale 1ns/1ps
module swh_link_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic lowPowerBuild,
  // link pins
  input wire logic hubResetLowInput,
  input wire logic wakeHostOe,
  input wire logic wakeHubOe,
  input wire logic sclHostOe,
  input wire logic sdaHostOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // hub drive of the shared line
  lp_no_irq_a: assert property (lowPowerBuild |-> !wakeHubOe)
    else $error("irq driven by low-power hub");
  irq_excl_a: assert property (wakeHubOe |-> !wakeHostOe)
    else $error("irq while host drives line");
  reset_quiet_a: assert property (!hubResetLowInput |-> !wakeHubOe)
    else $error("hub drove line in reset");
  // reset hold and strap level stay put until release
  rst_hold_a: assert property ($rose(reset_n) |-> (!hubResetLowInput)[*6])
    else $error("hub reset released early");
  strap_hold_a: assert property (!hubResetLowInput && wakeHostOe |=> wakeHostOe)
    else $error("strap dropped in reset");
  // wake lead: no clock driven until the lead time is over
  wake_lead_a: assert property ($rose(wakeHostOe) && hubResetLowInput |-> (!sclHostOe)[*5])
    else $error("bus started inside wake lead");
  wake_keep_a: assert property ($rose(wakeHostOe) && hubResetLowInput |-> wakeHostOe[*6])
    else $error("wake line released too soon");
  bus_hold_a: assert property (lowPowerBuild && (sclHostOe || sdaHostOe) |-> wakeHostOe)
    else $error("bus active without wake line");
endmodule : swh_link_asserts

// ### verification/sensor_hub_wake_handshake_bench.sv
// bench joining host end and hub end over the link interface
// assumes shortened timing parameters; hub reset follows host reset pin
`timescale 1ns/1ps
module sensor_hub_wake_handshake_bench;
  import swh_pkg::*;
  localparam int BW = 8, BR = 6, AR = 10, RP = 12, RH = 8, WL = 5, PP = 60;
  logic sys_clk = 0, reset_n = 0, lowPower = 0, wantBoot = 0, hubRstN;
  logic rtcEvent = 0, busBusy = 0, sdaHub = 0, cmdValid = 0, reportTaken = 0, takeReq = 0;
  logic sensorEvent = 0, appValid = 1;
  logic xferReq = 0, xferDone = 0, sclDrive = 0, sdaDrive = 0, restartReq = 0;
  logic [23:0] cmdBytes = 0;
  logic bootMode, cmdReady, asleep, reportPulse, xferGo, pollDue, hubIrq;
  logic [7:0] reportRate;
  int seed = 10, compares = 0, n_mismatch = 0, gap = 0, gaps[$];
  int n, k, r, e;
  swh_link_if link();
  assign hubRstN = reset_n & link.hubResetLowInput;
  swh_hub_end #(.BOOT_WAIT(BW), .BOOT_READY(BR), .APP_READY(AR), .REPORT_PERIOD(RP)) i_swh_hub_end (
    .sys_clk(sys_clk), .reset_n(hubRstN), .clkEn(1'b1), .link(link.hub),
    .lowPowerBuild(lowPower), .appValid(appValid), .rtcEvent(rtcEvent),
    .sensorEvent(sensorEvent),
    .busBusy(busBusy), .sdaDrive(sdaHub), .cmdValid(cmdValid), .cmdBytes(cmdBytes),
    .reportTaken(reportTaken), .bootMode(bootMode), .cmdReady(cmdReady), .asleep(asleep),
    .reportPulse(reportPulse), .reportRate(reportRate));
  swh_host_end #(.RST_HOLD(RH), .WAKE_LEAD(WL), .POLL_PERIOD(PP)) i_swh_host_end (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1), .link(link.host),
    .wantBoot(wantBoot), .restartReq(restartReq), .lowPowerHub(lowPower), .xferReq(xferReq),
    .xferDone(xferDone), .sclDrive(sclDrive), .sdaDrive(sdaDrive), .xferGo(xferGo),
    .pollDue(pollDue), .hubIrq(hubIrq));
  swh_link_asserts i_swh_link_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
    .lowPowerBuild(lowPower), .hubResetLowInput(link.hubResetLowInput),
    .wakeHostOe(link.wakeHostOe), .wakeHubOe(link.wakeHubOe),
    .sclHostOe(link.sclHostOe), .sdaHostOe(link.sdaHostOe));
  // 50 MHz clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // report spacing model; low-power reports are taken at once
  always @(posedge sys_clk) begin
    gap <= reportPulse ? 1 : gap + 1;
    if (reportPulse) gaps.push_back(gap);
    reportTaken <= lowPower ? reportPulse : takeReq;
  end
  task automatic chk(input string nm, input int e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // full reset, then wait for the hub to take commands
  task automatic rst(input logic lp, input logic boot);
    int m;
    @(posedge sys_clk);
    reset_n <= 0;
    lowPower <= lp;
    wantBoot <= boot;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1;
    for (m = 0; cmdReady !== 1 && m < 500; m++) @(posedge sys_clk);
    e = RH + (boot ? BR : AR);
    #1 chk("startup", 1, m >= e && m <= e + 4);
    chk("bootMode", 0, bootMode);
  endtask : rst
  task automatic cmd(input logic [23:0] b);
    @(posedge sys_clk);
    cmdValid <= 1;
    cmdBytes <= b;
    @(posedge sys_clk);
    cmdValid <= 0;
  endtask : cmd
  // woken exchange; req low means the poll timer starts it
  task automatic xfer(input logic req);
    int m;
    @(posedge sys_clk);
    xferReq <= req;
    for (m = 0; xferGo !== 1 && m < 100; m++) @(posedge sys_clk);
    chk("lead", 1, m > WL && m < WL + 4);
    repeat (8) begin
      @(posedge sys_clk);
      xferReq <= 0;
      busBusy <= 1;
      {sclDrive, sdaDrive, sdaHub} <= 3'($random(seed));
      #1 chk("sdaLine", !(sdaDrive || sdaHub), link.sdaLine);
    end
    #1 chk("awake", 0, asleep);
    @(posedge sys_clk);
    {sclDrive, sdaDrive, sdaHub, busBusy, xferDone} <= 5'h01;
    @(posedge sys_clk);
    xferDone <= 0;
    for (m = 0; asleep !== 1 && m < 20; m++) @(posedge sys_clk);
    #1 chk("resleep", 1, asleep);
  endtask : xfer
  // tests
  initial begin
    rst(0, 1);
    repeat (BW + 4) @(posedge sys_clk);
    #1 chk("fallback", 0, cmdReady);
    $display("test boot fallback done");
    rst(0, 1);
    cmd(BOOT_ENTER_CMD);
    repeat (BW + 4) @(posedge sys_clk);
    #1 chk("bootEnter", 1, bootMode & cmdReady);
    $display("test boot entry done");
    @(posedge sys_clk);
    appValid <= 0;
    rst(0, 1);
    repeat (BW + 4) @(posedge sys_clk);
    #1 chk("noAppStay", 1, cmdReady & ~bootMode);
    @(posedge sys_clk);
    appValid <= 1;
    $display("test boot without app done");
    rst(0, 0);
    for (k = 0; k < 2; k++) begin
      r = k ? 2 + $unsigned($random(seed)) % 3 : 0;
      e = (r == 0) ? 1 : r;
      cmd({OUT_MODE_CMD, r[7:0]});
      gaps.delete();
      for (n = 0; gaps.size() < 2 && n < 2000; n++) @(posedge sys_clk);
      @(posedge sys_clk);
      #1 chk("rate", e, reportRate);
      chk("period", RP * e, gaps[1]);
      chk("irqSet", 1, hubIrq);
      @(posedge sys_clk);
      takeReq <= 1;
      @(posedge sys_clk);
      takeReq <= 0;
      repeat (2) @(posedge sys_clk);
      #1 chk("irqClear", 0, hubIrq);
    end
    $display("test report rate done");
    @(posedge sys_clk);
    restartReq <= 1;
    @(posedge sys_clk);
    restartReq <= 0;
    #1 chk("restartRst", 0, link.hubResetLowInput);
    for (n = 0; cmdReady !== 1 && n < 500; n++) @(posedge sys_clk);
    #1 chk("restart", 1, n >= RH + AR && n <= RH + AR + 4);
    $display("test host restart done");
    rst(1, 0);
    for (n = 0; asleep !== 1 && n < 40; n++) @(posedge sys_clk);
    #1 chk("sleep", 1, asleep);
    xfer(1);
    @(posedge sys_clk);
    rtcEvent <= 1;
    @(posedge sys_clk);
    rtcEvent <= 0;
    #1 chk("rtcWake", 0, asleep);
    for (n = 0; asleep !== 1 && n < 20; n++) @(posedge sys_clk);
    #1 chk("rtcResleep", 1, asleep);
    @(posedge sys_clk);
    sensorEvent <= 1;
    @(posedge sys_clk);
    sensorEvent <= 0;
    #1 chk("sensorWake", 0, asleep);
    $display("test wake handshake done");
    for (n = 0; pollDue !== 1 && n < PP + 5; n++) @(posedge sys_clk);
    #1 chk("pollDue", 1, pollDue);
    xfer(0);
    $display("test polling done");
    final_report();
  end
  // watchdog well past the expected few hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule : sensor_hub_wake_handshake_bench
